//--- hdl/dac_serial_write_port.sv
// serial write port and mode control for an 8-bit voltage converter
// Contract
// - While frame select is low each falling serial clock edge shifts the data pin into 16 bits.
// - The serial clock may run up to 30 MHz and the host must not exceed that; the port needs each clock level to last two system clocks.
// - On the 16th falling edge the frame executes, loading the code and the mode.
// - Frame layout MSB first: two ignored bits, two mode bits, eight code bits, four ignored.
// - Frame select rising before the 16th edge clears the shifter and changes nothing else; the port still adds one to the abort count.
// - Reset fills the code register with zeros, output at 0 V, until a complete write.
// - Mode bits 13 and 12 pick normal, 1 kilohm, 100 kilohm or three-state.
// - Any power-down mode disconnects the buffer and powers down; the 1 kilohm and 100 kilohm modes also select their termination.
// - Power-down leaves the stored code untouched for when normal mode returns.
// - The code is straight binary 0 to 255, output equal to code over 256 of supply.
//
// Added by the designer: the Wishbone register port and the register addresses.
`timescale 1ns/100ps
`include "dac_port_defines.svh"
module dac_serial_write_port (
   // system clock and reset
   input  wire logic                       sys_clk,
   input  wire logic                       rst,
   // serial link pins from the host
   input  wire logic                       frameSelN,
   input  wire logic                       serialClk,
   input  wire logic                       serialData,
   // classic wishbone slave
   input  wire logic                       wb_cyc_i,
   input  wire logic                       wb_stb_i,
   input  wire logic                       wb_we_i,
   input  wire logic [`WB_ADR_BITS-1:0]    wb_adr_i,
   input  wire logic [3:0]                 wb_sel_i,
   input  wire logic [31:0]                wb_dat_i,
   output logic      [31:0]                wb_dat_o,
   output logic                            wb_ack_o,
   // converter and output stage controls
   output logic      [7:0]                 dacCode,
   output dac_port_pkg::op_mode_t          opMode,
   output logic                            ampEnable,
   output logic                            termOneK,
   output logic                            termHundredK,
   output logic                            biasEnable,
   output logic                            frameDone
);
   import dac_port_pkg::*;

   // the link clock is only sampled: each of its levels must last two system clocks,
   // so full link speed needs a system clock far above the one used here

   logic selLevel;
   logic clkLevel;
   logic datLevel;

   pin_sync u_sync_sel (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .pinIn     (frameSelN),
      .initLevel (1'b1),
      .level     (selLevel)
   );
   pin_sync u_sync_clk (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .pinIn     (serialClk),
      .initLevel (1'b0),
      .level     (clkLevel)
   );
   pin_sync u_sync_dat (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .pinIn     (serialData),
      .initLevel (1'b0),
      .level     (datLevel)
   );

   typedef struct packed {
      logic        selPrev;
      logic        clkPrev;
      link_state_t link;
      logic [15:0] shifter;
      logic [4:0]  count;
      logic [7:0]  code;
      op_mode_t    mode;
      logic [15:0] frames;
      logic [15:0] aborts;
      logic        done;
      logic        amp;
      logic        t1k;
      logic        t100k;
      logic        bias;
      logic [31:0] rdata;
      logic        ack;
   } port_state_t;

   port_state_t st;
   port_state_t next_st;

   logic        selFall;
   logic        selRise;
   logic        clkFall;
   logic        busReq;
   logic [15:0] shifted;
   logic [31:0] adr;
   op_mode_t    execMode;

   assign selFall  = st.selPrev & ~selLevel;
   assign selRise  = ~st.selPrev & selLevel;
   assign clkFall  = st.clkPrev & ~clkLevel;
   assign busReq   = wb_cyc_i & wb_stb_i & ~st.ack;
   assign shifted  = {st.shifter[14:0], datLevel};
   assign adr      = {{(32-`WB_ADR_BITS){1'b0}}, wb_adr_i};
   assign execMode = op_mode_t'(shifted[`MODE_HI_POS:`MODE_LO_POS]);

   always_comb begin
      next_st = st;
      next_st.selPrev = selLevel;
      next_st.clkPrev = clkLevel;
      next_st.done    = 1'b0;
      next_st.ack     = 1'b0;
      case (st.link)
         LINK_IDLE: begin
            if (selFall) begin
               next_st.link    = LINK_SHIFT;
               next_st.shifter = `SHIFT_RESET;
               next_st.count   = `COUNT_RESET;
            end
         end
         LINK_SHIFT: begin
            if (selRise) begin
               // early rise abandons the frame; code and mode keep their values
               next_st.link    = LINK_IDLE;
               next_st.shifter = `SHIFT_RESET;
               next_st.count   = `COUNT_RESET;
               next_st.aborts  = st.aborts + 16'h0001;
            end else if (clkFall) begin
               next_st.shifter = shifted;
               next_st.count   = st.count + 5'h01;
               if (st.count == `FRAME_LAST) begin
                  // bits 15:14 and 3:0 carry nothing
                  next_st.code   = shifted[`DATA_MSB_POS:`DATA_LSB_POS];
                  next_st.mode   = execMode;
                  next_st.link   = LINK_DONE;
                  next_st.done   = 1'b1;
                  next_st.frames = st.frames + 16'h0001;
               end
            end
         end
         LINK_DONE: begin
            // parked low or not, only a fresh high then low restarts
            if (selRise) begin
               next_st.link = LINK_IDLE;
            end
         end
         default: begin
            next_st.link = LINK_IDLE;
         end
      endcase
      // read data is registered at the request edge and stands with ack
      if (busReq) begin
         next_st.ack   = 1'b1;
         next_st.rdata = `REG_MISS;
         case (adr)
            `REG_DATA: begin
               next_st.rdata = {24'h00_0000, st.code};
            end
            `REG_MODE: begin
               next_st.rdata = {30'h0000_0000, st.mode};
            end
            `REG_STATUS: begin
               next_st.rdata = {st.aborts, st.frames};
            end
            default: begin
               next_st.rdata = `REG_MISS;
            end
         endcase
      end
      // a write lands at the edge where the master sees ack; the link wins a collision
      if (st.ack && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !next_st.done) begin
         if (adr == `REG_DATA) begin
            next_st.code = wb_dat_i[7:0];
         end else if (adr == `REG_MODE) begin
            next_st.mode = op_mode_t'(wb_dat_i[1:0]);
         end
      end
      // derived last so a bus mode write moves the output stage in the same cycle
      // power-down only reroutes the output; the stored code stays
      next_st.amp   = (next_st.mode == MODE_NORMAL);
      next_st.bias  = (next_st.mode == MODE_NORMAL);
      next_st.t1k   = (next_st.mode == MODE_PD_1K);
      next_st.t100k = (next_st.mode == MODE_PD_100K);
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st         <= '0;
         st.selPrev <= 1'b1;
         st.link    <= LINK_IDLE;
         st.code    <= `CODE_RESET;
         st.mode    <= MODE_NORMAL;
         st.amp     <= 1'b1;
         st.bias    <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign wb_dat_o     = st.rdata;
   assign wb_ack_o     = st.ack;
   assign dacCode      = st.code;
   assign opMode       = st.mode;
   assign ampEnable    = st.amp;
   assign termOneK     = st.t1k;
   assign termHundredK = st.t100k;
   assign biasEnable   = st.bias;
   assign frameDone    = st.done;
endmodule : dac_serial_write_port

//--- hdl/dac_port_defines.svh
// constants for the serial converter write port
`ifndef DAC_PORT_DEFINES_SVH
`define DAC_PORT_DEFINES_SVH
`define FRAME_BITS       5'h10
`define FRAME_LAST       5'h0F
`define MODE_HI_POS      13
`define MODE_LO_POS      12
`define DATA_MSB_POS     11
`define DATA_LSB_POS     4
`define CODE_RESET       8'h00
`define MODE_RESET       2'b00
`define SHIFT_RESET      16'h0000
`define COUNT_RESET      5'h00
`define REG_DATA         32'h0000_0000
`define REG_MODE         32'h0000_0004
`define REG_STATUS       32'h0000_0008
`define REG_MISS         32'h0000_0000
`define SCLK_MAX_MHZ     30
`define SYS_CLK_MHZ      50
`define WB_ADR_BITS      4
`endif

//--- hdl/dac_port_pkg.sv
// types for the serial converter write port
package dac_port_pkg;
   typedef enum logic [1:0] {
      MODE_NORMAL = 2'b00,
      MODE_PD_1K  = 2'b01,
      MODE_PD_100K = 2'b10,
      MODE_PD_HIZ = 2'b11
   } op_mode_t;
   typedef enum logic [1:0] {
      LINK_IDLE  = 2'b00,
      LINK_SHIFT = 2'b01,
      LINK_DONE  = 2'b10
   } link_state_t;
endpackage : dac_port_pkg

//--- hdl/pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module pin_sync (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rst,
   // pin in, filtered level out
   input  wire logic pinIn,
   input  wire logic initLevel,
   output logic      level
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } sync_t;
   sync_t st;
   sync_t next_st;
   always_comb begin
      next_st = st;
      next_st.s1 = pinIn;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      // only the second and third stage vote
      if (st.s2 == st.s3) begin
         next_st.lvl = st.s3;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st <= {initLevel, initLevel, initLevel, initLevel};
      end else begin
         st <= next_st;
      end
   end
   assign level = st.lvl;
endmodule : pin_sync

//--- dv/dac_host_model.sv
// host serial port model driving frames into the write port
`timescale 1ns/100ps
module dac_host_model (
   // clock
   input  wire logic sys_clk,
   // serial pins
   output logic      frameSelN  = 1'b1,
   output logic      serialClk  = 1'b0,
   output logic      serialData = 1'b0
);
   // clock idles low outside frames; 160 ns period stays far under the limit
   task automatic send(input logic [23:0] w, input int n, input logic keepLow);
      frameSelN <= 1'b0;
      repeat (4) @(posedge sys_clk);
      for (int i = n - 1; i >= 0; i--) begin // msb first
         serialClk  <= 1'b1;
         serialData <= w[i]; // settled long before the falling edge
         repeat (4) @(posedge sys_clk);
         serialClk <= 1'b0;
         repeat (4) @(posedge sys_clk);
      end
      if (!keepLow) begin // a byte host parks low between bytes
         frameSelN  <= 1'b1; // high well over the minimum gap
         serialData <= ~serialData; // released line, not a stale bit
         repeat (12) @(posedge sys_clk);
      end
   endtask : send
endmodule : dac_host_model

//--- dv/dac_serial_write_port_sva.sv
// concurrent checks on the write port outputs
`timescale 1ns/100ps
module dac_serial_write_port_sva (
   // clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   rst,
   // observed outputs and the bus write enable
   input  wire logic                   wb_ack_o,
   input  wire logic                   wb_we_i,
   input  wire logic [7:0]             dacCode,
   input  wire dac_port_pkg::op_mode_t opMode,
   input  wire logic                   ampEnable,
   input  wire logic                   termOneK,
   input  wire logic                   termHundredK,
   input  wire logic                   biasEnable,
   input  wire logic                   frameDone
);
   import dac_port_pkg::*;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   reset_clear_a: assert property (disable iff (1'b0)
      rst |=> dacCode == 8'h00 && opMode == MODE_NORMAL) else $error("reset state wrong");
   code_source_a: assert property (
      $changed(dacCode) |-> frameDone || $past(wb_ack_o)) else $error("stray code");
   mode_source_a: assert property (
      $changed(opMode) |-> frameDone || $past(wb_ack_o)) else $error("stray mode");
   code_keep_a: assert property (
      $changed(opMode) && !frameDone |-> $stable(dacCode)) else $error("code lost");
   amp_follow_a: assert property (
      ampEnable == (opMode == MODE_NORMAL)) else $error("amp wrong");
   bias_follow_a: assert property (
      biasEnable == (opMode == MODE_NORMAL)) else $error("bias wrong");
   one_k_a: assert property (
      termOneK == (opMode == MODE_PD_1K)) else $error("1k wrong");
   hundred_k_a: assert property (
      termHundredK == (opMode == MODE_PD_100K)) else $error("100k wrong");
   done_pulse_a: assert property (
      frameDone |=> !frameDone [*8]) else $error("repeated execute");
   cover property (frameDone);
   cover property (opMode == MODE_PD_HIZ);
   cover property (wb_ack_o && wb_we_i);
endmodule : dac_serial_write_port_sva
bind dac_serial_write_port dac_serial_write_port_sva dac_serial_write_port_sva_inst (.sys_clk,
   .rst, .wb_ack_o, .wb_we_i, .dacCode, .opMode, .ampEnable, .termOneK, .termHundredK,
   .biasEnable, .frameDone);

//--- dv/dac_serial_write_port_test.sv
// testbench for the serial converter write port
`timescale 1ns/100ps
module dac_serial_write_port_test;
   import dac_port_pkg::*;
   logic sys_clk = 1'b0, rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, q;
   logic wb_ack_o, frameSelN, serialClk, serialData;
   logic ampEnable, biasEnable, termOneK, termHundredK, frameDone;
   logic [7:0] dacCode;
   op_mode_t opMode;
   int failCount = 0, samplesChecked = 0, cycles = 0, doneSeen = 0;
   initial forever #10 sys_clk = ~sys_clk;
   dac_host_model host (.sys_clk, .frameSelN, .serialClk, .serialData);
   dac_serial_write_port dac_serial_write_port_inst (.sys_clk, .rst, .frameSelN, .serialClk,
      .serialData, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
      .wb_ack_o, .dacCode, .opMode, .ampEnable, .termOneK, .termHundredK,
      .biasEnable, .frameDone);
   task automatic finalReport;
      if (failCount == 0 && samplesChecked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : finalReport
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         failCount++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
      do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      @(posedge sys_clk);
   endtask : wb
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (frameDone === 1'b1) doneSeen <= doneSeen + 1;
      if (cycles == 5000) begin
         failCount++;
         finalReport;
      end
   end
   initial begin
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (8) @(posedge sys_clk);
      cmp(dacCode, 32'h0000_0000);
      for (int m = 0; m < 4; m++) begin // every mode, junk in ignored bits
         host.send({8'h00, 2'b10, m[1:0], 8'hF0 | 8'(m), 4'h6}, 16, 1'b0);
         cmp(opMode, m);
         cmp(dacCode, 8'hF0 | 8'(m));
         cmp({ampEnable, biasEnable, termOneK, termHundredK}, {m == 0, m == 0, m == 1, m == 2});
      end
      host.send(24'h00_0FF0, 15, 1'b0); // abort one edge short
      cmp({opMode, dacCode}, {2'b11, 8'hF3});
      host.send(24'h00_0007, 8, 1'b1); // two bytes then a stray third
      host.send(24'h00_00E0, 8, 1'b1);
      host.send(24'h00_00FF, 8, 1'b0);
      cmp({opMode, dacCode}, {2'b00, 8'h7E});
      cmp(doneSeen, 32'h0000_0005);
      wb(4'h8, 1'b0, 32'h0000_0000);
      cmp(q, 32'h0001_0005);
      wb(4'h4, 1'b1, 32'h0000_0003);
      cmp({opMode, dacCode}, {2'b11, 8'h7E});
      wb(4'h0, 1'b1, 32'h0000_0081);
      wb(4'h0, 1'b0, 32'h0000_0000);
      cmp(q, 32'h0000_0081);
      wb(4'hC, 1'b0, 32'h0000_0000);
      cmp(q, 32'h0000_0000);
      rst <= 1'b1;
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      cmp({opMode, dacCode}, 32'h0000_0000);
      finalReport;
   end
endmodule : dac_serial_write_port_test
